// ### lcd_sub_instruction_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_sub_instruction_decoder_test;
  import lsid_pkg::*;
  logic       clk, arst_n, cmd_wr, cmd_data_select, sub_mode;
  logic [7:0] cmd_byte, contrast_level, contrast_staged, duty_lines;
  logic [3:0] bias_divisor, block1_start, block2_start;
  logic [2:0] boost_multiple;
  logic [5:0] inverse_lines;
  logic [4:0] block1_units, block2_units;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  lsid_host i_lsid_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_data_select(cmd_data_select),
    .cmd_byte(cmd_byte));
  lsid_decoder #(.CAPS(6)) i_lsid_decoder (.clk(clk), .arst_n(arst_n), .cmd_wr(cmd_wr),
    .cmd_data_select(cmd_data_select), .cmd_byte(cmd_byte), .sub_mode(sub_mode),
    .contrast_level(contrast_level), .contrast_staged(contrast_staged),
    .bias_divisor(bias_divisor), .boost_multiple(boost_multiple),
    .inverse_lines(inverse_lines), .duty_lines(duty_lines), .block1_start(block1_start),
    .block1_units(block1_units), .block2_start(block2_start), .block2_units(block2_units));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic s(input logic [7:0] b);
    i_lsid_host.send(b);
  endtask
  // Outputs register at the taking edge, so a look 1 ns later sees them
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("sub", 8'h00, {7'h00, sub_mode});
    chk("contrast", 8'hFF, contrast_level);
    chk("bias", 8'h0C, {4'h0, bias_divisor});
    chk("boost", 8'h06, {5'h00, boost_multiple});
    chk("inverse", 8'h00, {2'h0, inverse_lines});
    chk("duty", 8'h80, duty_lines);
    chk("b1units", 8'h10, {3'h0, block1_units});
    for (int i = 0; i < 9; i++) begin
      s({4'hB, i[3:0]});
      chk("bias", (i < 8) ? 8'(i + 4) : 8'h0C, {4'h0, bias_divisor});
    end
    for (int i = 0; i < 5; i++) begin
      s({5'h06, i[2:0]});
      chk("boost", (i < 4) ? 8'(i + 2) : 8'h06, {5'h00, boost_multiple});
    end
    s(8'h8A);
    chk("staged main", 8'hFF, contrast_staged);
    s(8'h70);
    chk("sub", 8'h01, {7'h00, sub_mode});
    s(8'hB5);
    chk("bias in sub", 8'h0C, {4'h0, bias_divisor});
    s(8'h00);
    s(8'h22);
    s(8'hC4);
    s(8'hE5);
    chk("duty staged", 8'h80, duty_lines);
    s(8'h40);
    chk("duty", 8'h38, duty_lines);
    chk("b1start", 8'h00, {4'h0, block1_start});
    chk("b1units", 8'h02, {3'h0, block1_units});
    chk("b2start", 8'h04, {4'h0, block2_start});
    chk("b2units", 8'h05, {3'h0, block2_units});
    chk("bias kept", 8'h0C, {4'h0, bias_divisor});
    s(8'h62);
    s(8'h5C);
    chk("inverse", 8'h2C, {2'h0, inverse_lines});
    s(8'h8A);
    s(8'h95);
    chk("staged", 8'hA5, contrast_staged);
    chk("contrast held", 8'hFF, contrast_level);
    s(8'hA0);
    chk("contrast", 8'hA5, contrast_level);
    s(8'h71);
    chk("sub", 8'h00, {7'h00, sub_mode});
    s(8'h40);
    chk("duty main", 8'h38, duty_lines);
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("duty reset", 8'h80, duty_lines);
    chk("contrast reset", 8'hFF, contrast_level);
    chk("staged reset", 8'hFF, contrast_staged);
    chk("b2units reset", 8'h00, {3'h0, block2_units});
    chk("inverse reset", 8'h00, {2'h0, inverse_lines});
    s(8'h70);
    chk("sub after reset", 8'h01, {7'h00, sub_mode});
    wrap_up();
  end
endmodule // lcd_sub_instruction_decoder_test
`default_nettype wire

// ### lsid_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module lsid_decoder #(
  parameter int CAPS = 6
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_data_select,
  input  wire logic [7:0] cmd_byte,
  output logic            sub_mode,
  output logic [7:0]      contrast_level,
  output logic [7:0]      contrast_staged,
  output logic [3:0]      bias_divisor,
  output logic [2:0]      boost_multiple,
  output logic [5:0]      inverse_lines,
  output logic [7:0]      duty_lines,
  output logic [3:0]      block1_start,
  output logic [4:0]      block1_units,
  output logic [3:0]      block2_start,
  output logic [4:0]      block2_units
);
  import lsid_pkg::*;

  // Wiring below two capacitors cannot boost at all
  if (CAPS < 2 || CAPS > 6) begin : g_caps_bad
    $error("CAPS must be 2..6");
  end

  // ----------------------------------------------------------------
  // Command strobe
  // ----------------------------------------------------------------
  // Strobe comes from same-clock port logic, so no synchroniser
  logic       cmd_v;
  logic       sub_r;
  logic [7:0] con_r, con_stage_r, duty_r;
  logic [3:0] bias_r, b1s_r, b2s_r, ps_b1s_r, ps_b2s_r;
  logic [2:0] boost_r;
  logic [5:0] inv_r;
  logic [4:0] b1u_r, b2u_r, ps_b1u_r, ps_b2u_r;
  logic [4:0] tot_units;
  logic [3:0] bias_fld;
  logic [2:0] boost_fld;

  assign cmd_v = cmd_wr && !cmd_data_select;

  // ----------------------------------------------------------------
  // Table select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_r <= 1'b0;
    end else if (cmd_v && !sub_r && cmd_byte == SUB_ENTER) begin
      sub_r <= 1'b1;
    end else if (cmd_v && sub_r && cmd_byte == SUB_EXIT) begin
      sub_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Partial display staging and activation
  // ----------------------------------------------------------------
  // Staged values only reach the drive side on activation, so a half
  // written block pair never disturbs the running display.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_b1s_r <= 4'h0;
      ps_b1u_r <= UNITS_FULL;
      ps_b2s_r <= 4'h0;
      ps_b2u_r <= 5'h00;
    end else if (cmd_v && sub_r) begin
      if (cmd_byte[7:4] == PRE_B1_START) ps_b1s_r <= cmd_byte[3:0];
      if (cmd_byte[7:5] == PRE_B1_COUNT) ps_b1u_r <= cmd_byte[4:0];
      if (cmd_byte[7:4] == PRE_B2_START) ps_b2s_r <= cmd_byte[3:0];
      if (cmd_byte[7:5] == PRE_B2_COUNT) ps_b2u_r <= cmd_byte[4:0];
    end
  end

  // Full-screen block one ignores block two
  always_comb begin
    if (ps_b1u_r >= UNITS_FULL) tot_units = UNITS_FULL;
    else tot_units = 5'(ps_b1u_r + ps_b2u_r);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      b1s_r  <= 4'h0;
      b1u_r  <= UNITS_FULL;
      b2s_r  <= 4'h0;
      b2u_r  <= 5'h00;
      duty_r <= 8'h80;
    end else if (cmd_v && sub_r && cmd_byte == PART_ON) begin
      b1s_r  <= ps_b1s_r;
      b1u_r  <= ps_b1u_r;
      b2s_r  <= ps_b2s_r;
      b2u_r  <= ps_b2u_r;
      duty_r <= 8'(tot_units * LINES_PER_U);
    end
  end

  // ----------------------------------------------------------------
  // Inverse line count
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inv_r <= INV_RST;
    end else if (cmd_v && sub_r && cmd_byte[7:4] == PRE_INV_HI && cmd_byte[3:2] == 2'b00) begin
      inv_r[5:4] <= cmd_byte[1:0];
    end else if (cmd_v && sub_r && cmd_byte[7:4] == PRE_INV_LO) begin
      inv_r[3:0] <= cmd_byte[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Contrast level
  // ----------------------------------------------------------------
  // Regulator sees a new level only on the apply command, never a
  // mix of old and new nibbles.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      con_stage_r <= CONTRAST_RST;
      con_r       <= CONTRAST_RST;
    end else if (cmd_v && sub_r) begin
      if (cmd_byte[7:4] == PRE_CON_HI) con_stage_r[7:4] <= cmd_byte[3:0];
      if (cmd_byte[7:4] == PRE_CON_LO) con_stage_r[3:0] <= cmd_byte[3:0];
      if (cmd_byte == CONTRAST_GO) con_r <= con_stage_r;
    end
  end

  // ----------------------------------------------------------------
  // Bias and booster (main table)
  // ----------------------------------------------------------------
  assign bias_fld  = cmd_byte[3] ? BIAS_RST : cmd_byte[3:0];
  assign boost_fld = cmd_byte[2] ? BOOST_RST : cmd_byte[2:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bias_r <= BIAS_RST;
    end else if (cmd_v && !sub_r && cmd_byte[7:4] == PRE_BIAS) begin
      bias_r <= bias_fld;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boost_r <= BOOST_RST;
    end else if (cmd_v && !sub_r && cmd_byte[7:3] == PRE_BOOST) begin
      boost_r <= boost_fld;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sub_mode        = sub_r;
  assign contrast_level  = con_r;
  assign contrast_staged = con_stage_r;
  // Field 0..7 means divisor 4..11, fields 8..15 mean 12
  assign bias_divisor    = 4'(bias_r + 4'h4);
  // Multiple shifts down by missing capacitors; fields 4..7 give the wiring's own
  // multiple. Fields above the wiring are refused by the host, so no clamp there.
  assign boost_multiple  = (boost_r == BOOST_RST)
                           ? 3'(CAPS)
                           : 3'(boost_r + 3'(CAPS) - 3'h4);
  assign inverse_lines   = inv_r;
  assign duty_lines      = duty_r;
  assign block1_start    = b1s_r;
  assign block1_units    = b1u_r;
  assign block2_start    = b2s_r;
  assign block2_units    = b2u_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence enter_s;
    cmd_v && !sub_r && cmd_byte == SUB_ENTER;
  endsequence
  sequence exit_s;
    cmd_v && sub_r && cmd_byte == SUB_EXIT;
  endsequence

  sub_enter_a: assert property (@(posedge clk) disable iff (!arst_n)
    enter_s |=> sub_mode) else $error("enter not taken");
  sub_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
    exit_s |=> !sub_mode) else $error("exit not taken");
  part_duty_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && sub_r && cmd_byte == PART_ON) |=> duty_lines == $past(8'(tot_units * 8'h08)))
    else $error("duty wrong");
  part_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && sub_r && cmd_byte == PART_ON) |=> $stable(bias_divisor) && $stable(contrast_level))
    else $error("drive changed");
  contrast_apply_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && sub_r && cmd_byte == CONTRAST_GO) |=> contrast_level == $past(con_stage_r))
    else $error("contrast not applied");
  contrast_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && sub_r && cmd_byte[7:4] == 4'h8) |=> contrast_staged[7:4] == $past(cmd_byte[3:0]))
    else $error("contrast nibble");
  bias_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && !sub_r && cmd_byte[7:3] == 5'h17) |=> bias_divisor == 4'hC)
    else $error("bias top code");
  inv_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_v && sub_r && cmd_byte[7:4] == 4'h5) |=> inverse_lines[3:0] == $past(cmd_byte[3:0]))
    else $error("inverse low");
endmodule // lsid_decoder
`default_nettype wire

// ### lsid_host.sv
`timescale 1ns/1ns
`default_nettype none
module lsid_host (
  input  wire logic       clk,
  output logic            cmd_wr,
  output logic            cmd_data_select,
  output logic [7:0]      cmd_byte
);
  initial begin
    cmd_wr = 1'b0;
    cmd_data_select = 1'b1;
    cmd_byte = 8'h00;
  end
  // Idle byte is inverted so a stale value never passes for a command
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1;
    cmd_wr = 1'b1;
    cmd_data_select = 1'b0;
    cmd_byte = b;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    cmd_data_select = 1'b1;
    cmd_byte = ~b;
  endtask
endmodule // lsid_host
`default_nettype wire

// ### lsid_pkg.sv
package lsid_pkg;
  // ----------------------------------------------------------------
  // Command codes and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_ENTER     = 8'h70;
  localparam logic [7:0] SUB_EXIT      = 8'h71;
  localparam logic [7:0] PART_ON       = 8'h40;
  localparam logic [7:0] CONTRAST_GO   = 8'hA0;
  localparam logic [3:0] PRE_B1_START  = 4'h0;
  localparam logic [2:0] PRE_B1_COUNT  = 3'h1;
  localparam logic [3:0] PRE_B2_START  = 4'hC;
  localparam logic [2:0] PRE_B2_COUNT  = 3'h7;
  localparam logic [3:0] PRE_INV_HI    = 4'h6;
  localparam logic [3:0] PRE_INV_LO    = 4'h5;
  localparam logic [3:0] PRE_CON_HI    = 4'h8;
  localparam logic [3:0] PRE_CON_LO    = 4'h9;
  localparam logic [3:0] PRE_BIAS      = 4'hB;
  localparam logic [4:0] PRE_BOOST     = 5'h06;
  // ----------------------------------------------------------------
  // Reset values and geometry
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTRAST_RST  = 8'hFF;
  localparam logic [3:0] BIAS_RST      = 4'h8;
  localparam logic [2:0] BOOST_RST     = 3'h4;
  localparam logic [5:0] INV_RST       = 6'h00;
  localparam logic [4:0] UNITS_FULL    = 5'h10;
  localparam logic [7:0] LINES_PER_U   = 8'h08;
  localparam logic [2:0] CAPS_FULL     = 3'h6;
endpackage
